// file: verilog/sse_pkg.sv
// Constants, command codes and bit layouts of the status event registers
package sse_pkg;

    localparam int          DATA_W        = 16;
    localparam int          STD_W         = 8;
    localparam int          STB_W         = 8;
    localparam int          N_SENSOR      = 4;
    localparam int          N_PIN         = 14;

    // Controller commands and queries arriving from the message parser
    typedef enum logic [3:0] {
        CMD_POLL_SET  = 4'h0,
        CMD_POLL_QRY  = 4'h1,
        CMD_FLAG_QRY  = 4'h2,
        CMD_ESE_SET   = 4'h3,
        CMD_ESE_QRY   = 4'h4,
        CMD_STD_QRY   = 4'h5,
        CMD_DEV_COND  = 4'h6,
        CMD_DEV_EVT   = 4'h7,
        CMD_QUES_COND = 4'h8,
        CMD_QUES_EVT  = 4'h9,
        CMD_OPC       = 4'hA,
        CMD_OTHER     = 4'hB
    } sse_cmd_t;

    // Device state flag layout, sensors A to D
    localparam int          DEV_CONN_POS [N_SENSOR] = '{1, 2, 7, 8};
    localparam int          DEV_ERR_POS  [N_SENSOR] = '{3, 4, 9, 10};
    localparam int          DEV_REAR_POS [N_SENSOR] = '{5, 6, 11, 12};
    localparam int          DEV_KEY_POS   = 14;
    localparam logic [15:0] DEV_USED_MASK = 16'h5FFE;

    // Questionable state flag layout
    localparam int          QUES_POWER_POS  = 3;
    localparam int          QUES_WINDOW_POS = 4;
    localparam int          QUES_CAL_POS    = 8;
    localparam int          QUES_SELFT_POS  = 9;
    localparam int          QUES_WARN_POS   = 14;
    localparam logic [15:0] QUES_USED_MASK  = 16'h4318;

    // Standard event flag layout
    localparam int          STD_OPC_POS   = 0;
    localparam int          STD_QERR_POS  = 2;
    localparam int          STD_DERR_POS  = 3;
    localparam int          STD_EERR_POS  = 4;
    localparam int          STD_CERR_POS  = 5;
    localparam int          STD_USER_POS  = 6;
    localparam int          STD_PON_POS   = 7;
    localparam logic [7:0]  STD_USED_MASK = 8'hFD;
    localparam logic [7:0]  STD_RESET     = 8'h80;
    localparam logic [7:0]  ESE_RESET     = 8'h00;
    localparam logic [7:0]  POLL_RESET    = 8'h00;
    localparam int          STB_ESB_POS   = 5;

    // Codes queued to the error queue, 16-bit two's complement
    localparam logic [15:0] ERR_CODE_CMD  = 16'hFF9C;
    localparam logic [15:0] ERR_CODE_EXE  = 16'hFF38;
    localparam logic [15:0] ERR_CODE_DEV  = 16'hFED4;

endpackage

// file: verilog/sse_event_reg.sv
// Condition-to-event latch with read-clear, rising transitions only
`timescale 1ns/1ps

module sse_event_reg
    import sse_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    input  wire logic [DATA_W-1:0] cond,
    input  wire logic [DATA_W-1:0] used_mask,
    input  wire logic              clr,
    output logic      [DATA_W-1:0] evt_q
);

    logic [DATA_W-1:0] cond_prev_q;
    logic [DATA_W-1:0] rise;

    assign rise = cond & ~cond_prev_q & used_mask;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            cond_prev_q <= 16'h0000;
        else
            cond_prev_q <= cond;
    end

    // A new transition in the clearing cycle survives the clear
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            evt_q <= 16'h0000;
        else
            evt_q <= (clr ? 16'h0000 : evt_q) | rise;
    end

endmodule

// file: verilog/sse_status_regs.sv
// Individual status, device, questionable and standard event registers
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////

module sse_status_regs
    import sse_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    input  wire logic              cmd_valid,
    input  wire sse_pkg::sse_cmd_t cmd_code,
    input  wire logic [15:0]       cmd_wdata,
    input  wire logic              rsp_take,
    input  wire logic              exec_idle,
    input  wire logic              dev_err_evt,
    input  wire logic              exe_err_evt,
    input  wire logic              cmd_err_evt,
    input  wire logic [7:0]        stb_in,
    input  wire logic [3:0]        sensor_conn,
    input  wire logic [3:0]        sensor_err,
    input  wire logic [3:0]        sensor_rear,
    input  wire logic              key_held,
    input  wire logic              local_key,
    input  wire logic              ques_power_sum,
    input  wire logic              ques_window_sum,
    input  wire logic              ques_cal_sum,
    input  wire logic              selftest_fail_flag,
    input  wire logic              warning,
    output logic                   rsp_valid_q,
    output logic [15:0]            rsp_data_q,
    output logic                   individual_status_flag_q,
    output logic                   esb_flag_q,
    output logic                   err_push_q,
    output logic [15:0]            err_code_q
);

    logic [N_PIN-1:0]  pin_s1_q;
    logic [N_PIN-1:0]  pin_s2_q;
    logic              local_prev_q;
    logic              local_rise;
    logic [15:0]       dev_cond;
    logic [15:0]       ques_cond;
    logic [15:0]       dev_evt_q;
    logic [15:0]       ques_evt_q;
    logic              dev_clr;
    logic              ques_clr;
    logic [7:0]        poll_mask_q;
    logic [7:0]        ese_q;
    logic [7:0]        std_evt_q;
    logic [7:0]        std_set;
    logic [7:0]        stb_full;
    logic              std_clr;
    logic              opc_pend_q;
    logic              rsp_pend_q;
    logic              is_query;
    logic              qerr;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the first stage feeds only the second
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_s1_q <= 14'h0000;
            pin_s2_q <= 14'h0000;
        end
        else
        begin
            pin_s1_q <= {local_key, key_held, sensor_rear, sensor_err, sensor_conn};
            pin_s2_q <= pin_s1_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            local_prev_q <= 1'b0;
        else
            local_prev_q <= pin_s2_q[13];
    end

    assign local_rise = pin_s2_q[13] & ~local_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // Condition views
    always_comb
    begin
        dev_cond              = 16'h0000;
        dev_cond[DEV_KEY_POS] = pin_s2_q[12];
        for (int i = 0; i < N_SENSOR; i++)
        begin
            dev_cond[DEV_CONN_POS[i]] = pin_s2_q[i];
            dev_cond[DEV_ERR_POS[i]]  = pin_s2_q[4 + i];
            dev_cond[DEV_REAR_POS[i]] = pin_s2_q[8 + i];
        end
    end

    always_comb
    begin
        ques_cond                  = 16'h0000;
        ques_cond[QUES_POWER_POS]  = ques_power_sum;
        ques_cond[QUES_WINDOW_POS] = ques_window_sum;
        ques_cond[QUES_CAL_POS]    = ques_cal_sum;
        ques_cond[QUES_SELFT_POS]  = selftest_fail_flag;
        ques_cond[QUES_WARN_POS]   = warning;
    end

    assign is_query = cmd_code != CMD_POLL_SET && cmd_code != CMD_ESE_SET
                      && cmd_code != CMD_OPC && cmd_code != CMD_OTHER;
    assign dev_clr  = cmd_valid && cmd_code == CMD_DEV_EVT;
    assign ques_clr = cmd_valid && cmd_code == CMD_QUES_EVT;
    assign std_clr  = cmd_valid && cmd_code == CMD_STD_QRY;

    // Event views latch rising transitions only
    sse_event_reg u_dev_evt (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .cond      (dev_cond),
        .used_mask (DEV_USED_MASK),
        .clr       (dev_clr),
        .evt_q     (dev_evt_q)
    );

    sse_event_reg u_ques_evt (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .cond      (ques_cond),
        .used_mask (QUES_USED_MASK),
        .clr       (ques_clr),
        .evt_q     (ques_evt_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Masks written by the controller
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            poll_mask_q <= POLL_RESET;
        else if (cmd_valid && cmd_code == CMD_POLL_SET)
            poll_mask_q <= cmd_wdata[7:0];
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            ese_q <= ESE_RESET;
        else if (cmd_valid && cmd_code == CMD_ESE_SET)
            ese_q <= cmd_wdata[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Answer tracking and query errors
    assign qerr = (rsp_take && !rsp_pend_q) || (cmd_valid && rsp_pend_q);

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            rsp_pend_q <= 1'b0;
        else if (cmd_valid && is_query)
            rsp_pend_q <= 1'b1;
        else if (rsp_take || cmd_valid)
            rsp_pend_q <= 1'b0;
    end

    // Completion waits on the executor's idle level, never on a count
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            opc_pend_q <= 1'b0;
        else if (cmd_valid && cmd_code == CMD_OPC)
            opc_pend_q <= 1'b1;
        else if (exec_idle)
            opc_pend_q <= 1'b0;
    end

    always_comb
    begin
        std_set               = 8'h00;
        std_set[STD_OPC_POS]  = opc_pend_q && exec_idle;
        std_set[STD_QERR_POS] = qerr;
        std_set[STD_DERR_POS] = dev_err_evt;
        std_set[STD_EERR_POS] = exe_err_evt;
        std_set[STD_CERR_POS] = cmd_err_evt;
        std_set[STD_USER_POS] = local_rise;
    end

    // Power-on bit comes from the reset value; sets win over read-clear
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            std_evt_q <= STD_RESET;
        else
            std_evt_q <= ((std_clr ? 8'h00 : std_evt_q) | std_set)
                         & STD_USED_MASK;
    end

    // One code per cycle; a command error outranks the others
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            err_push_q <= 1'b0;
            err_code_q <= 16'h0000;
        end
        else
        begin
            err_push_q <= cmd_err_evt | exe_err_evt | dev_err_evt;
            if (cmd_err_evt)
                err_code_q <= ERR_CODE_CMD;
            else if (exe_err_evt)
                err_code_q <= ERR_CODE_EXE;
            else if (dev_err_evt)
                err_code_q <= ERR_CODE_DEV;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status byte summary and individual status
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            esb_flag_q <= 1'b0;
        else
            esb_flag_q <= |(std_evt_q & ese_q);
    end

    always_comb
    begin
        stb_full              = stb_in;
        stb_full[STB_ESB_POS] = esb_flag_q;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            individual_status_flag_q <= 1'b0;
        else
            individual_status_flag_q <= |(stb_full & poll_mask_q);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Query answers, one cycle after the query
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= 16'h0000;
        end
        else
        begin
            rsp_valid_q <= cmd_valid && is_query;
            if (cmd_valid)
            begin
                unique case (cmd_code)
                    CMD_POLL_QRY:  rsp_data_q <= {8'h00, poll_mask_q};
                    CMD_FLAG_QRY:  rsp_data_q <= {15'h0000, individual_status_flag_q};
                    CMD_ESE_QRY:   rsp_data_q <= {8'h00, ese_q};
                    CMD_STD_QRY:   rsp_data_q <= {8'h00, std_evt_q};
                    CMD_DEV_COND:  rsp_data_q <= dev_cond & DEV_USED_MASK;
                    CMD_DEV_EVT:   rsp_data_q <= dev_evt_q;
                    CMD_QUES_COND: rsp_data_q <= ques_cond;
                    CMD_QUES_EVT:  rsp_data_q <= ques_evt_q;
                    CMD_POLL_SET, CMD_ESE_SET, CMD_OPC, CMD_OTHER:
                                   rsp_data_q <= rsp_data_q;
                    default:       rsp_data_q <= 16'h0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_flag_poll_mask: assert property (@(posedge clk_sys) disable iff (!rst_b)
        individual_status_flag_q == $past(|(stb_full & poll_mask_q)) || $past(!rst_b))
        else $error("Status flag differs from masked status byte");

    a_poll_read_back: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (cmd_valid && cmd_code == CMD_POLL_SET) ##1 (cmd_valid && cmd_code == CMD_POLL_QRY)
        |=> rsp_valid_q && rsp_data_q == {8'h00, $past(cmd_wdata[7:0], 2)})
        else $error("Poll mask did not read back");

    a_dev_unused_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (cmd_valid && (cmd_code == CMD_DEV_EVT || cmd_code == CMD_QUES_EVT))
        |=> (rsp_data_q & ~(($past(cmd_code) == CMD_DEV_EVT) ? DEV_USED_MASK
                                                              : QUES_USED_MASK)) == 16'h0000)
        else $error("Unused event bit read as one");

    a_bit15_never: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !dev_evt_q[15] && !ques_evt_q[15] && !dev_cond[15] && !ques_cond[15])
        else $error("Bit 15 asserted");

    a_std_read_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
        std_clr |=> std_evt_q == ($past(std_set) & STD_USED_MASK)
                    && rsp_data_q[7:0] == $past(std_evt_q))
        else $error("Event read did not return then clear");

    a_opc_complete: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (cmd_valid && cmd_code == CMD_OPC) ##1 (!exec_idle [*2]) ##1 exec_idle
        |=> std_evt_q[STD_OPC_POS])
        else $error("Operation complete bit not set");

    a_query_error: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (rsp_take && !rsp_pend_q) |=> std_evt_q[STD_QERR_POS])
        else $error("Unrequested read not flagged");

    a_user_request: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(pin_s2_q[13]) |=> std_evt_q[STD_USER_POS])
        else $error("Local key not flagged");

    a_cmd_err_code: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cmd_err_evt |=> err_push_q && err_code_q == ERR_CODE_CMD && std_evt_q[STD_CERR_POS])
        else $error("Command error code missing");

    a_exe_err_code: assert property (@(posedge clk_sys) disable iff (!rst_b)
        exe_err_evt && !cmd_err_evt
        |=> err_push_q && err_code_q == ERR_CODE_EXE && std_evt_q[STD_EERR_POS])
        else $error("Execution error code missing");

    a_dev_err_code: assert property (@(posedge clk_sys) disable iff (!rst_b)
        dev_err_evt && !cmd_err_evt && !exe_err_evt
        |=> err_push_q && err_code_q == ERR_CODE_DEV && std_evt_q[STD_DERR_POS])
        else $error("Device error code missing");

    a_key_event: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(dev_cond[DEV_KEY_POS]) |=> dev_evt_q[DEV_KEY_POS])
        else $error("Key press not latched");

    a_selftest_event: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(ques_cond[QUES_SELFT_POS]) |=> ques_evt_q[QUES_SELFT_POS])
        else $error("Self-test failure not latched");

    a_flag_query: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (cmd_valid && cmd_code == CMD_FLAG_QRY)
        |=> rsp_valid_q && rsp_data_q == {15'h0000, $past(individual_status_flag_q)})
        else $error("Status flag query answer wrong");

    a_esb_summary: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (|(std_evt_q & ese_q)) [*2] |-> esb_flag_q)
        else $error("Summary bit not raised");

endmodule

// file: verif/sse_ctrl_model.sv
// Behavioural remote controller that sends commands and collects answers
`timescale 1ns/1ps

module sse_ctrl_model
    import sse_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         rsp_valid_q,
    input  wire logic [15:0]  rsp_data_q,
    output sse_pkg::sse_cmd_t cmd_code,
    output logic              cmd_valid,
    output logic [15:0]       cmd_wdata,
    output logic              rsp_take
);
    import sse_pkg::*;

    initial
    begin
        cmd_valid = 1'b0;
        cmd_code  = CMD_OTHER;
        cmd_wdata = 16'h0000;
        rsp_take  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mask writes and queries, except those of write_read, go through this one-cycle strobe
    task automatic send(input sse_cmd_t code, input logic [15:0] wdata);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_code  <= code;
        cmd_wdata <= wdata;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
    endtask

    // Collecting the answer; also used alone to read with nothing pending
    task automatic take();
        @(posedge clk_sys);
        rsp_take <= 1'b1;
        @(posedge clk_sys);
        rsp_take <= 0;
    endtask

    // Mask write and its query on back-to-back edges, answer then collected
    task automatic write_read(input sse_cmd_t wcode, input logic [15:0] wdata,
                              input sse_cmd_t qcode, output logic [15:0] data);
        data = 16'h0000;
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_code  <= wcode;
        cmd_wdata <= wdata;
        @(posedge clk_sys);
        cmd_code  <= qcode;
        cmd_wdata <= 16'h0000;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        @(negedge clk_sys);
        if (rsp_valid_q === 1'b1)
            data = rsp_data_q;
        take();
    endtask

    // Answer is always collected, so later commands never meet a pending one
    task automatic query(input sse_cmd_t code, output logic [15:0] data, output logic ok);
        ok   = 1'b0;
        data = 16'h0000;
        send(code, 16'h0000);
        for (int i = 0; i < 4 && ok !== 1'b1; i++)
        begin
            @(negedge clk_sys);
            if (rsp_valid_q === 1'b1)
            begin
                ok   = 1'b1;
                data = rsp_data_q;
            end
        end
        take();
    endtask
endmodule

// file: verif/testbench.sv
// Self-checking testbench of the status event registers
`timescale 1ns/1ps

module testbench;
    import sse_pkg::*;

    logic              clk_sys, rst_b, rsp_take, cmd_valid, exec_idle;
    logic              dev_err_evt, exe_err_evt, cmd_err_evt, key_held, local_key;
    logic              ques_power_sum, ques_window_sum, ques_cal_sum;
    logic              selftest_fail_flag, warning, rsp_valid_q, individual_status_flag_q;
    logic              esb_flag_q, err_push_q;
    sse_cmd_t          cmd_code;
    logic [15:0]       cmd_wdata, rsp_data_q, err_code_q;
    logic [7:0]        stb_in;
    logic [3:0]        sensor_conn, sensor_err, sensor_rear;
    int                fail_count, samples_checked, cycles;

    sse_status_regs DUT (.clk_sys(clk_sys), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_take(rsp_take),
        .exec_idle(exec_idle), .dev_err_evt(dev_err_evt), .exe_err_evt(exe_err_evt),
        .cmd_err_evt(cmd_err_evt), .stb_in(stb_in), .sensor_conn(sensor_conn),
        .sensor_err(sensor_err), .sensor_rear(sensor_rear), .key_held(key_held),
        .local_key(local_key), .ques_power_sum(ques_power_sum),
        .ques_window_sum(ques_window_sum), .ques_cal_sum(ques_cal_sum),
        .selftest_fail_flag(selftest_fail_flag), .warning(warning),
        .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
        .individual_status_flag_q(individual_status_flag_q), .esb_flag_q(esb_flag_q),
        .err_push_q(err_push_q), .err_code_q(err_code_q));

    sse_ctrl_model ctrl (.clk_sys(clk_sys), .rsp_valid_q(rsp_valid_q),
        .rsp_data_q(rsp_data_q), .cmd_code(cmd_code), .cmd_valid(cmd_valid),
        .cmd_wdata(cmd_wdata), .rsp_take(rsp_take));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask

    // A query whose answer never comes shows up as a missing answer, and its value reads as zero in the compare against the expected word
    task automatic qchk(input string name, input sse_cmd_t code, input logic [15:0] exp);
        logic [15:0] data;
        logic        ok;
        ctrl.query(code, data, ok);
        chk_bit("answer", 1'b1, ok);
        chk_word(name, exp, data);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_power_on();
        qchk("std_first", CMD_STD_QRY, 16'h0080);
        qchk("std_again", CMD_STD_QRY, 16'h0000);
    endtask

    task automatic t_parallel_poll();
        logic [15:0] data;
        stb_in <= 8'h40;
        ctrl.send(CMD_POLL_SET, 16'h0040);
        repeat (3) @(negedge clk_sys);
        chk_bit("flag_bit6", 1'b1, individual_status_flag_q);
        qchk("flag_query", CMD_FLAG_QRY, 16'h0001);
        qchk("poll_query", CMD_POLL_QRY, 16'h0040);
        ctrl.write_read(CMD_POLL_SET, 16'h003F, CMD_POLL_QRY, data);
        chk_word("poll_back", 16'h003F, data);
        repeat (3) @(negedge clk_sys);
        chk_bit("flag_masked", 1'b0, individual_status_flag_q);
        qchk("flag_query0", CMD_FLAG_QRY, 16'h0000);
    endtask

    task automatic t_query_error();
        ctrl.send(CMD_ESE_SET, 16'h0004);
        ctrl.take();
        repeat (3) @(negedge clk_sys);
        chk_bit("esb_set", 1'b1, esb_flag_q);
        qchk("ese_query", CMD_ESE_QRY, 16'h0004);
        qchk("std_qerr", CMD_STD_QRY, 16'h0004);
        repeat (3) @(negedge clk_sys);
        chk_bit("esb_clear", 1'b0, esb_flag_q);
        // Second query sent over an uncollected answer
        ctrl.send(CMD_ESE_QRY, 16'h0000);
        ctrl.send(CMD_ESE_QRY, 16'h0000);
        ctrl.take();
        qchk("std_qerr2", CMD_STD_QRY, 16'h0004);
    endtask

    task automatic t_errors();
        logic [15:0] codes [3] = '{ERR_CODE_DEV, ERR_CODE_EXE, ERR_CODE_CMD};
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk_sys);
            dev_err_evt <= (i == 0);
            exe_err_evt <= (i == 1);
            cmd_err_evt <= (i == 2);
            @(posedge clk_sys);
            {dev_err_evt, exe_err_evt, cmd_err_evt} <= 3'b000;
            @(negedge clk_sys);
            chk_bit("err_push", 1'b1, err_push_q);
            chk_word("err_code", codes[i], err_code_q);
        end
        @(posedge clk_sys);
        local_key <= 1'b1;
        repeat (5) @(posedge clk_sys);
        qchk("std_errs", CMD_STD_QRY, 16'h0078);
    endtask

    task automatic t_opc();
        ctrl.send(CMD_OPC, 16'h0000);
        repeat (4) @(posedge clk_sys);
        qchk("std_busy", CMD_STD_QRY, 16'h0000);
        // Executor goes idle on the third edge after a fresh completion request
        ctrl.send(CMD_OPC, 16'h0000);
        repeat (2) @(posedge clk_sys);
        exec_idle <= 1'b1;
        repeat (3) @(posedge clk_sys);
        qchk("std_opc", CMD_STD_QRY, 16'h0001);
    endtask

    task automatic t_device();
        sensor_conn <= 4'b0101;
        sensor_err  <= 4'b1000;
        sensor_rear <= 4'b0011;
        key_held    <= 1'b1;
        repeat (4) @(posedge clk_sys);
        qchk("dev_cond", CMD_DEV_COND, 16'h44E2);
        qchk("dev_evt", CMD_DEV_EVT, 16'h44E2);
        key_held <= 1'b0;
        repeat (4) @(posedge clk_sys);
        qchk("dev_evt0", CMD_DEV_EVT, 16'h0000);
        qchk("dev_cond_up", CMD_DEV_COND, 16'h04E2);
        {sensor_conn, sensor_err, sensor_rear, key_held} <= 13'h1FFF;
        repeat (4) @(posedge clk_sys);
        qchk("dev_all", CMD_DEV_COND, 16'h5FFE);
    endtask

    task automatic t_questionable();
        {ques_power_sum, ques_window_sum, ques_cal_sum, selftest_fail_flag, warning} <= 5'h1F;
        repeat (3) @(posedge clk_sys);
        qchk("ques_cond", CMD_QUES_COND, 16'h4318);
        qchk("ques_evt", CMD_QUES_EVT, 16'h4318);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Whole run is under two hundred cycles; the ceiling only catches a hang
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            stop_test();
        end
    end

    initial
    begin
        rst_b = 1'b0;
        {exec_idle, dev_err_evt, exe_err_evt, cmd_err_evt, key_held, local_key} = 6'h00;
        {ques_power_sum, ques_window_sum, ques_cal_sum, selftest_fail_flag, warning} = 5'h00;
        stb_in      = 8'h00;
        sensor_conn = 4'h0;
        sensor_err  = 4'h0;
        sensor_rear = 4'h0;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_power_on();
        t_parallel_poll();
        t_query_error();
        t_errors();
        t_opc();
        t_device();
        t_questionable();
        stop_test();
    end
endmodule
